// ===== tost_regs.sv
// status word, payload length and send mode registers with event capture and interrupt
//
// Added by the designer: the plain strobed port.
`default_nettype none
module tost_regs (
    input  wire logic        mclk,
    input  wire logic        nrst,
    // register port
    input  wire logic [4:0]  regAddr,
    input  wire logic [31:0] regWrData,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic      [31:0] regRdData,
    // engine state
    input  wire logic        engineBusy,
    input  wire logic [2:0]  engineOp,
    input  wire logic        engineInit,
    input  wire logic        sendActive,
    input  wire logic        waitAck,
    input  wire logic        windowStall,
    // receive path events, one-cycle pulses, with rxBufFull a level
    input  wire logic        rxPacket,
    input  wire logic        rxBufFull,
    input  wire logic        rxLost,
    input  wire logic        rxSeqErr,
    input  wire logic        rxFin,
    input  wire logic        rxRst,
    // controls toward the transmit and receive paths
    output logic      [15:0] txPayloadLength,
    output logic      [2:0]  sendModeControl,
    output logic             pshFlag,
    output logic      [31:0] timeoutValue,
    output logic             resendPacket,
    output logic             dupAckRequest,
    output logic             windowRetransmit,
    output logic             rxDiscard,
    output logic             irq
);
    logic [31:0] status;
    logic [31:0] next_status;
    logic [31:0] irqStatus;
    logic [31:0] next_irqStatus;
    logic [31:0] irqMask;
    logic [31:0] next_irqMask;
    logic [15:0] next_txPayloadLength;
    logic [2:0]  next_sendModeControl;
    logic [31:0] next_timeoutValue;
    logic [31:0] next_regRdData;
    logic [31:0] events;
    logic        ackExpire;
    logic        winExpire;
    logic        next_resendPacket;
    logic        next_dupAckRequest;
    logic        next_windowRetransmit;
    logic        next_rxDiscard;

    function automatic logic hit(input logic [4:0] a, input logic [4:0] r);
        hit = (a == r);
    endfunction : hit

    tost_timer #(.W(32)) ackTimer (
        .mclk   (mclk),
        .nrst   (nrst),
        .run    (waitAck),
        .limit  (timeoutValue),
        .expire (ackExpire)
    );

    tost_timer #(.W(32)) winTimer (
        .mclk   (mclk),
        .nrst   (nrst),
        .run    (windowStall & sendActive),
        .limit  (timeoutValue),
        .expire (winExpire)
    );

    always_comb begin
        events = '0;
        events[tost_pkg::BIT_ACK_TMO]    = ackExpire;
        events[tost_pkg::BIT_RX_RECOVER] = rxLost | rxSeqErr | (rxPacket & rxBufFull);
        events[tost_pkg::BIT_WIN_TMO]    = winExpire;
        events[tost_pkg::BIT_FIN_SEND]   = rxFin & sendActive;
        events[tost_pkg::BIT_RX_DROP]    = rxPacket & rxBufFull;
        events[tost_pkg::BIT_RX_LOST]    = rxLost;
        events[tost_pkg::BIT_RX_RST]     = rxRst;
    end

    // action pulses toward the packet paths
    always_comb begin
        next_resendPacket     = ackExpire;
        next_dupAckRequest    = events[tost_pkg::BIT_RX_RECOVER];
        next_windowRetransmit = winExpire & sendModeControl[tost_pkg::SM_WIN_RETX];
        next_rxDiscard        = rxPacket & rxBufFull;
    end

    // the status word is only cleared by reinitialisation so polling never misses an event;
    // a new event in the reinit cycle still wins
    always_comb begin
        next_status = engineInit ? 32'h0 : status;
        next_status = next_status | (events & tost_pkg::STATUS_MASK);
    end

    always_comb begin
        next_irqStatus       = irqStatus;
        next_irqMask         = irqMask;
        next_txPayloadLength = txPayloadLength;
        next_sendModeControl = sendModeControl;
        next_timeoutValue    = timeoutValue;
        if (regWr) begin
            if (hit(regAddr, tost_pkg::ADDR_TIMEOUT)) begin
                next_timeoutValue = regWrData;
            end
            // out-of-range lengths are dropped, the old value stays usable
            if (hit(regAddr, tost_pkg::ADDR_PAYLOAD) &&
                regWrData[15:0] >= tost_pkg::PAYLOAD_MIN &&
                regWrData[15:0] <= tost_pkg::PAYLOAD_MAX) begin
                next_txPayloadLength = regWrData[15:0];
            end
            if (hit(regAddr, tost_pkg::ADDR_SENDMODE)) begin
                next_sendModeControl = regWrData[2:0];
            end
            if (hit(regAddr, tost_pkg::ADDR_IRQSTAT)) begin
                next_irqStatus = irqStatus & ~regWrData;
            end
            if (hit(regAddr, tost_pkg::ADDR_IRQMASK)) begin
                next_irqMask = regWrData & tost_pkg::STATUS_MASK;
            end
        end
        // set after clear so a same-cycle event survives
        next_irqStatus = next_irqStatus | (events & tost_pkg::STATUS_MASK);
    end

    always_comb begin
        next_regRdData = '0;
        if (regRd) begin
            if (hit(regAddr, tost_pkg::ADDR_CMD)) begin
                next_regRdData = {28'h0, engineOp, engineBusy};
            end else if (hit(regAddr, tost_pkg::ADDR_TIMEOUT)) begin
                next_regRdData = status;
            end else if (hit(regAddr, tost_pkg::ADDR_PAYLOAD)) begin
                next_regRdData = {16'h0, txPayloadLength};
            end else if (hit(regAddr, tost_pkg::ADDR_SENDMODE)) begin
                next_regRdData = {29'h0, sendModeControl};
            end else if (hit(regAddr, tost_pkg::ADDR_IRQSTAT)) begin
                next_regRdData = irqStatus;
            end else if (hit(regAddr, tost_pkg::ADDR_IRQMASK)) begin
                next_regRdData = irqMask;
            end
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            status           <= '0;
            irqStatus        <= '0;
            irqMask          <= '0;
            txPayloadLength  <= tost_pkg::PAYLOAD_RESET;
            sendModeControl  <= tost_pkg::SENDMODE_RESET;
            timeoutValue     <= tost_pkg::TIMEOUT_RESET;
            regRdData        <= '0;
            resendPacket     <= 1'b0;
            dupAckRequest    <= 1'b0;
            windowRetransmit <= 1'b0;
            rxDiscard        <= 1'b0;
        end else begin
            status           <= next_status;
            irqStatus        <= next_irqStatus;
            irqMask          <= next_irqMask;
            txPayloadLength  <= next_txPayloadLength;
            sendModeControl  <= next_sendModeControl;
            timeoutValue     <= next_timeoutValue;
            regRdData        <= next_regRdData;
            resendPacket     <= next_resendPacket;
            dupAckRequest    <= next_dupAckRequest;
            windowRetransmit <= next_windowRetransmit;
            rxDiscard        <= next_rxDiscard;
        end
    end

    assign pshFlag = sendModeControl[tost_pkg::SM_PSH];
    assign irq     = |(irqStatus & irqMask);

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    sequence ackWaitHit;
        waitAck && ackExpire;
    endsequence

    ack_timeout_a: assert property (ackWaitHit |=> status[tost_pkg::BIT_ACK_TMO] && resendPacket)
        else $error("ack timeout not flagged or packet not resent");
    rx_recover_a: assert property ((rxLost || rxSeqErr) |=> status[tost_pkg::BIT_RX_RECOVER] && dupAckRequest)
        else $error("rx recovery not flagged");
    win_timeout_a: assert property (winExpire |=> status[tost_pkg::BIT_WIN_TMO])
        else $error("window timeout not flagged");
    fin_send_a: assert property (rxFin && sendActive |=> status[tost_pkg::BIT_FIN_SEND])
        else $error("fin during send not flagged");
    rx_drop_a: assert property (rxPacket && rxBufFull |=> rxDiscard && status[tost_pkg::BIT_RX_DROP])
        else $error("full-buffer packet not dropped");
    rx_lost_a: assert property (rxLost |=> status[tost_pkg::BIT_RX_LOST])
        else $error("rx loss not flagged");
    rx_rst_a: assert property (rxRst |=> status[tost_pkg::BIT_RX_RST])
        else $error("rst flag not flagged");
    len_range_a: assert property (txPayloadLength >= tost_pkg::PAYLOAD_MIN &&
                                  txPayloadLength <= tost_pkg::PAYLOAD_MAX)
        else $error("payload length out of range");
    len_hold_a: assert property (!(regWr && hit(regAddr, tost_pkg::ADDR_PAYLOAD)) |=> $stable(txPayloadLength))
        else $error("payload length changed without write");
    psh_flag_a: assert property (regWr && hit(regAddr, tost_pkg::ADDR_SENDMODE) |=>
                                 pshFlag == $past(regWrData[tost_pkg::SM_PSH]))
        else $error("psh flag does not follow send mode write");
    busy_read_a: assert property (regRd && hit(regAddr, tost_pkg::ADDR_CMD) |=>
                                  regRdData[tost_pkg::CMD_BUSY] == $past(engineBusy))
        else $error("busy flag read wrong");
    win_retx_a: assert property (winExpire && !sendModeControl[tost_pkg::SM_WIN_RETX] |=> !windowRetransmit)
        else $error("window retransmit while disabled");
    win_retx_on_a: assert property (winExpire && sendModeControl[tost_pkg::SM_WIN_RETX] |=> windowRetransmit)
        else $error("window retransmit missing while enabled");
    sticky_a: assert property (status[tost_pkg::BIT_RX_RST] && !engineInit |=> status[tost_pkg::BIT_RX_RST])
        else $error("status bit lost before reinit");
    timer_wait_a: assert property ($rose(waitAck) |-> !ackExpire [*2])
        else $error("ack timer expired too early");
endmodule : tost_regs
`default_nettype wire

// ===== tost_pkg.sv
// constants and register map of the offload status and transmit settings bank
// Notes on behaviour
// - ack timeout sets bit 5, resend packet
// - rx loss/full/sequence error sets bit 6, dup ack
// - small window timeout while sending sets bit 7
// - fin seen while sending sets bit 22
// - rx packet dropped on full buffer, bit 23
// - rx packet loss sets bit 27
// - rx rst flag sets bit 30
// - payload length is 16 bits, 1 to 16000
// - payload length resets to 1460 bytes
// - payload length persists across commands
// - send mode is 3-bit read/write field
// - send mode bit 1 drives tcp psh flag
// - timeout counter counts one clock per unit
// - command read bit 0 is busy flag
// - send mode bit 2 enables window retransmit
`default_nettype none
package tost_pkg;
    localparam int          ADDR_W         = 5;
    localparam int          DATA_W         = 32;
    localparam logic [4:0]  ADDR_CMD       = 5'h01;
    localparam logic [4:0]  ADDR_TIMEOUT   = 5'h09;
    localparam logic [4:0]  ADDR_PAYLOAD   = 5'h0a;
    localparam logic [4:0]  ADDR_SENDMODE  = 5'h0b;
    localparam logic [4:0]  ADDR_IRQSTAT   = 5'h10;
    localparam logic [4:0]  ADDR_IRQMASK   = 5'h11;

    localparam int          BIT_ACK_TMO    = 5;
    localparam int          BIT_RX_RECOVER = 6;
    localparam int          BIT_WIN_TMO    = 7;
    localparam int          BIT_FIN_SEND   = 22;
    localparam int          BIT_RX_DROP    = 23;
    localparam int          BIT_RX_LOST    = 27;
    localparam int          BIT_RX_RST     = 30;
    localparam logic [31:0] STATUS_MASK    = 32'h48c000e0;

    localparam logic [15:0] PAYLOAD_RESET  = 16'h05b4;
    localparam logic [15:0] PAYLOAD_MIN    = 16'h0001;
    localparam logic [15:0] PAYLOAD_MAX    = 16'h3e80;
    localparam logic [2:0]  SENDMODE_RESET = 3'h0;
    localparam int          SM_PSH         = 1;
    localparam int          SM_WIN_RETX    = 2;
    localparam logic [31:0] TIMEOUT_RESET  = 32'h00006000;
    localparam int          CMD_BUSY       = 0;
endpackage : tost_pkg
`default_nettype wire

// ===== tost_timer.sv
// wait timer: one count per clock, pulses each time the programmed limit is reached
`default_nettype none
module tost_timer #(
    parameter int W = 32
) (
    input  wire logic         mclk,
    input  wire logic         nrst,
    input  wire logic         run,
    input  wire logic [W-1:0] limit,
    output logic              expire
);
    // a one-bit counter cannot tell a zero limit from a reached one
    if (W < 2) begin : gWidthCheck
        $error("tost_timer width too small");
    end

    logic [W-1:0] count;
    logic [W-1:0] next_count;
    logic         next_expire;

    // dropping run restarts the wait; a hit rearms so a stalled wait repeats
    always_comb begin
        next_count  = '0;
        next_expire = 1'b0;
        if (run) begin
            if (count >= limit) begin
                next_expire = 1'b1;
            end else begin
                next_count = count + {{(W-1){1'b0}}, 1'b1};
            end
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            count  <= '0;
            expire <= 1'b0;
        end else begin
            count  <= next_count;
            expire <= next_expire;
        end
    end
endmodule : tost_timer
`default_nettype wire

// ===== tost_far_end.sv
// far-end model: turns a request code into one-cycle receive event pulses
`default_nettype none
module tost_far_end (
    input  wire logic       mclk,
    input  wire logic       nrst,
    input  wire logic       evGo,
    input  wire logic [2:0] evSel,
    output logic            rxLost,
    output logic            rxSeqErr,
    output logic            rxFin,
    output logic            rxRst,
    output logic            rxPacket
);
    timeunit 1ns;
    timeprecision 1ps;
    // each event lasts exactly one cycle, as a frame decoder would report it
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            {rxLost, rxSeqErr, rxFin, rxRst, rxPacket} <= 5'h00;
        end else begin
            rxLost   <= evGo && (evSel == 3'h0);
            rxSeqErr <= evGo && (evSel == 3'h1);
            rxFin    <= evGo && (evSel == 3'h2);
            rxRst    <= evGo && (evSel == 3'h3);
            rxPacket <= evGo && (evSel == 3'h4);
        end
    end
endmodule : tost_far_end
`default_nettype wire

// ===== test_tost_regs.sv
// register-level test of the offload status and transmit settings bank
`default_nettype none
module test_tost_regs;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk = 1'b0, nrst, regWr = 1'b0, regRd = 1'b0, evGo = 1'b0;
    logic [4:0]  regAddr = 5'h00;
    logic [31:0] regWrData = 32'h0, regRdData, timeoutValue, expStat;
    logic [2:0]  engineOp = 3'h1, evSel = 3'h0, sendModeControl;
    logic        engineBusy = 1'b0, engineInit = 1'b0, sendActive = 1'b0, waitAck = 1'b0;
    logic        windowStall = 1'b0, rxBufFull = 1'b0;
    logic        rxPacket, rxLost, rxSeqErr, rxFin, rxRst, pshFlag, irq;
    logic        resendPacket, dupAckRequest, windowRetransmit, rxDiscard;
    logic [15:0] txPayloadLength;
    logic [3:0]  seen = 4'h0;
    int          failCount = 0, checkCount = 0, n;

    always #10 mclk = ~mclk;
    always @(posedge mclk) seen <= seen | {rxDiscard, windowRetransmit, dupAckRequest, resendPacket};

    tost_regs dut (.mclk(mclk), .nrst(nrst), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
        .regRd(regRd), .regRdData(regRdData), .engineBusy(engineBusy), .engineOp(engineOp),
        .engineInit(engineInit), .sendActive(sendActive), .waitAck(waitAck), .windowStall(windowStall),
        .rxPacket(rxPacket), .rxBufFull(rxBufFull), .rxLost(rxLost), .rxSeqErr(rxSeqErr), .rxFin(rxFin),
        .rxRst(rxRst), .txPayloadLength(txPayloadLength), .sendModeControl(sendModeControl),
        .pshFlag(pshFlag), .timeoutValue(timeoutValue), .resendPacket(resendPacket),
        .dupAckRequest(dupAckRequest), .windowRetransmit(windowRetransmit), .rxDiscard(rxDiscard), .irq(irq));
    tost_far_end far (.mclk(mclk), .nrst(nrst), .evGo(evGo), .evSel(evSel), .rxLost(rxLost),
        .rxSeqErr(rxSeqErr), .rxFin(rxFin), .rxRst(rxRst), .rxPacket(rxPacket));

    task automatic closeOut;
        if (failCount == 0 && checkCount > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : closeOut
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checkCount++;
        if (got !== exp) begin
            failCount++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge mclk);
        regWr <= 1'b1; regAddr <= a; regWrData <= d;
        @(posedge mclk);
        regWr <= 1'b0;
    endtask : wr
    // read data stand only in the cycle after the strobe
    task automatic rdChk(input logic [4:0] a, input logic [31:0] exp);
        @(posedge mclk);
        regRd <= 1'b1; regAddr <= a;
        @(posedge mclk);
        regRd <= 1'b0;
        @(negedge mclk);
        chk(regRdData, exp);
        // hand back on a rising edge so callers drive by non-blocking assignment there
        @(posedge mclk);
    endtask : rdChk
    task automatic ev(input logic [2:0] s);
        @(posedge mclk);
        evGo <= 1'b1; evSel <= s;
        @(posedge mclk);
        evGo <= 1'b0;
        repeat (3) @(posedge mclk);
    endtask : ev

    initial begin
        repeat (5000) @(posedge mclk);
        failCount++;
        closeOut();
    end

    initial begin
        // a falling edge after time zero makes sure the asynchronous reset is seen
        #1 nrst <= 1'b0;
        repeat (3) @(posedge mclk);
        nrst <= 1'b1;
        rdChk(tost_pkg::ADDR_PAYLOAD, 32'h000005b4);
        chk(txPayloadLength, 16'h05b4);
        chk(timeoutValue, 32'h00006000);
        rdChk(tost_pkg::ADDR_SENDMODE, 32'h0);
        chk(pshFlag, 1'b0);
        rdChk(5'h1f, 32'h0);
        // payload writes outside 1 to 16000 are dropped
        wr(tost_pkg::ADDR_PAYLOAD, 32'h00003e80);
        rdChk(tost_pkg::ADDR_PAYLOAD, 32'h00003e80);
        wr(tost_pkg::ADDR_PAYLOAD, 32'h00003e81);
        wr(tost_pkg::ADDR_PAYLOAD, 32'h0);
        rdChk(tost_pkg::ADDR_PAYLOAD, 32'h00003e80);
        wr(tost_pkg::ADDR_PAYLOAD, 32'h00000001);
        engineBusy <= 1'b1; engineOp <= 3'h0;
        rdChk(tost_pkg::ADDR_CMD, 32'h1);
        engineBusy <= 1'b0; engineOp <= 3'h1;
        rdChk(tost_pkg::ADDR_CMD, 32'h2);
        rdChk(tost_pkg::ADDR_PAYLOAD, 32'h1);
        wr(tost_pkg::ADDR_SENDMODE, 32'hfffffffa);
        rdChk(tost_pkg::ADDR_SENDMODE, 32'h2);
        chk(sendModeControl, 3'h2);
        chk(pshFlag, 1'b1);
        // receive events accumulate in the status word
        ev(3'h3);
        expStat = 32'h40000000;
        chk(irq, 1'b0);
        rdChk(tost_pkg::ADDR_TIMEOUT, expStat);
        ev(3'h1);
        expStat |= 32'h40;
        rdChk(tost_pkg::ADDR_TIMEOUT, expStat);
        chk(seen, 4'h2);
        ev(3'h0);
        expStat |= 32'h08000000;
        rdChk(tost_pkg::ADDR_TIMEOUT, expStat);
        ev(3'h2);
        rdChk(tost_pkg::ADDR_TIMEOUT, expStat);
        sendActive <= 1'b1;
        ev(3'h2);
        expStat |= 32'h00400000;
        rdChk(tost_pkg::ADDR_TIMEOUT, expStat);
        rxBufFull <= 1'b1;
        ev(3'h4);
        rxBufFull <= 1'b0;
        expStat |= 32'h00800000;
        rdChk(tost_pkg::ADDR_TIMEOUT, expStat);
        chk(seen, 4'ha);
        // ack timer: limit 4 gives the resend pulse limit+2 edges after waitAck is driven
        wr(tost_pkg::ADDR_TIMEOUT, 32'h4);
        @(posedge mclk);
        waitAck <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
            @(negedge mclk);
        end while (resendPacket !== 1'b1 && n < 40);
        chk(n, 32'd6);
        chk(timeoutValue, 32'h4);
        @(posedge mclk);
        waitAck <= 1'b0;
        expStat |= 32'h20;
        rdChk(tost_pkg::ADDR_TIMEOUT, expStat);
        // window stall with retransmit disabled: flag only, no retransmit pulse
        windowStall <= 1'b1;
        repeat (7) @(posedge mclk);
        windowStall <= 1'b0;
        expStat |= 32'h80;
        rdChk(tost_pkg::ADDR_TIMEOUT, expStat);
        chk(seen, 4'hb);
        wr(tost_pkg::ADDR_SENDMODE, 32'h4);
        windowStall <= 1'b1;
        repeat (12) @(posedge mclk);
        windowStall <= 1'b0; sendActive <= 1'b0;
        rdChk(tost_pkg::ADDR_TIMEOUT, expStat);
        chk(seen, 4'hf);
        // interrupt: mask, raise, clear by writing one
        wr(tost_pkg::ADDR_IRQMASK, 32'h40000000);
        #1 chk(irq, 1'b1);
        wr(tost_pkg::ADDR_IRQSTAT, 32'h40000000);
        #1 chk(irq, 1'b0);
        rdChk(tost_pkg::ADDR_IRQSTAT, expStat & 32'hbfffffff);
        rdChk(tost_pkg::ADDR_TIMEOUT, expStat);
        @(posedge mclk);
        engineInit <= 1'b1;
        @(posedge mclk);
        engineInit <= 1'b0;
        rdChk(tost_pkg::ADDR_TIMEOUT, 32'h0);
        closeOut();
    end
endmodule : test_tost_regs
`default_nettype wire
